// ===== hdl/asr_ctrl.sv
`timescale 1ns/10ps

// Functional notes
// [RULE1] The memory holds 131,072 byte locations picked by a 17-bit word address.
// [RULE2] A write happens while low select and write strobe are low and high select is high.
// [RULE3] A read happens while low select and output gate are low and strobe and high select are high.
// [RULE4] The memory floats its data pins when deselected, gated off, or writing.
// [RULE5] With low select high or high select low the memory is in standby whatever the other pins do.
// [RULE6] The write interval is the overlap of both selects active and strobe low; any one leaving ends it.
// [RULE7] Write data is taken at the rising edge that ends the write, so data must be stable around it.
// [RULE8] A strobe-ended write with the gate low must last at least strobe-to-float delay plus data set-up.
// [RULE9] Deselecting together with the strobe rising keeps the data pins floating.
// [RULE10] The controller must not drive the data pins while the memory drives them.
// [RULE11] For a read the address must be valid no later than the selects go active.
module asr_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Request side
    input wire logic req_valid,
    input wire asr_pkg::asr_req_t req,
    output logic req_ready,
    // Answer side
    output logic rsp_valid,
    output logic rsp_write,
    output logic [asr_pkg::ASR_DATA_W-1:0] rsp_rdata,
    // Memory pins
    output asr_pkg::asr_pins_t pins,
    input wire logic [asr_pkg::ASR_DATA_W-1:0] data_pins_in
);
    import asr_pkg::*;

    asr_state_t state;
    asr_state_t next_state;
    logic [3:0] count;
    logic [3:0] next_count;
    asr_pins_t next_pins;
    logic next_rsp_valid;
    logic next_rsp_write;
    logic [ASR_DATA_W-1:0] next_rsp_rdata;
    logic [ASR_DATA_W-1:0] data_sync;
    logic take;
    logic cnt_done;

    // ==========================================================
    // Data pins come from outside the clock domain
    asr_pin_sync #(
        .WIDTH(ASR_DATA_W)
    ) u_data_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(data_pins_in),
        .pin_sync(data_sync)
    );

    assign req_ready = (state == ASR_IDLE);
    assign take = req_valid && req_ready;
    assign cnt_done = (count == 4'h1);

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            ASR_IDLE: begin
                if (take) begin
                    if (req.write) begin
                        next_state = ASR_WR_SETUP;
                    end else begin
                        next_count = ASR_RD_CYC;
                        next_state = ASR_RD_WAIT;
                    end
                end
            end
            ASR_RD_WAIT: begin
                // Access time plus the full synchroniser latency, or stale data is taken
                if (cnt_done) begin
                    next_count = ASR_TURN_CYC;
                    next_state = ASR_RD_TURN;
                end else begin
                    next_count = count - 4'h1;
                end
            end
            ASR_RD_TURN: begin
                // Let the memory release the bus before anyone drives it [RULE10]
                if (cnt_done) begin
                    next_state = ASR_IDLE;
                end else begin
                    next_count = count - 4'h1;
                end
            end
            ASR_WR_SETUP: begin
                next_count = ASR_WE_CYC;
                next_state = ASR_WR_STROBE;
            end
            ASR_WR_STROBE: begin
                // Strobe width covers both pulse width and float-plus-setup [RULE8]
                if (cnt_done) begin
                    next_state = ASR_WR_HOLD;
                end else begin
                    next_count = count - 4'h1;
                end
            end
            ASR_WR_HOLD: begin
                next_state = ASR_IDLE;
            end
            default: begin
                next_state = ASR_IDLE;
                next_count = 4'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ASR_IDLE;
            count <= 4'h0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // ==========================================================
    // Pin drive
    always_comb begin
        next_pins = pins;
        case (state)
            ASR_IDLE: begin
                // Idle keeps the memory deselected in standby [RULE5]
                next_pins.select_active_low = ASR_RST_SEL_N;
                next_pins.select_active_high = ASR_RST_SEL;
                next_pins.out_gate_n = ASR_RST_GATE_N;
                next_pins.wr_strobe_n = ASR_RST_STROBE_N;
                next_pins.data_pins_oe = 1'b0;
                if (take) begin
                    // Address and selects change on the same edge [RULE11] [RULE1]
                    next_pins.word_address_pins = req.addr;
                    next_pins.select_active_low = 1'b0;
                    next_pins.select_active_high = 1'b1;
                    if (req.write) begin
                        // Gate held high so the memory never drives during a write [RULE10] [RULE4]
                        next_pins.data_pins_out = req.wdata;
                        next_pins.data_pins_oe = 1'b1;
                    end else begin
                        next_pins.out_gate_n = 1'b0; // [RULE3]
                    end
                end
            end
            ASR_RD_WAIT: begin
                if (cnt_done) begin
                    next_pins.select_active_low = 1'b1;
                    next_pins.select_active_high = 1'b0;
                    next_pins.out_gate_n = 1'b1;
                end
            end
            ASR_RD_TURN: begin
                // Memory may still drive here, so we stay off the bus [RULE10]
                next_pins.data_pins_oe = 1'b0;
            end
            ASR_WR_SETUP: begin
                // Overlap opens here: both selects already active [RULE6] [RULE2]
                next_pins.wr_strobe_n = 1'b0;
            end
            ASR_WR_STROBE: begin
                if (cnt_done) begin
                    next_pins.wr_strobe_n = 1'b1; // [RULE7]
                end
            end
            ASR_WR_HOLD: begin
                // Data held past the ending edge; deselect only one cycle later [RULE7] [RULE9]
                next_pins.select_active_low = 1'b1;
                next_pins.select_active_high = 1'b0;
                next_pins.data_pins_oe = 1'b0;
            end
            default: begin
                // An unknown state parks the memory in standby
                next_pins.select_active_low = ASR_RST_SEL_N;
                next_pins.select_active_high = ASR_RST_SEL;
                next_pins.out_gate_n = ASR_RST_GATE_N;
                next_pins.wr_strobe_n = ASR_RST_STROBE_N;
                next_pins.data_pins_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pins.select_active_low <= ASR_RST_SEL_N;
            pins.select_active_high <= ASR_RST_SEL;
            pins.out_gate_n <= ASR_RST_GATE_N;
            pins.wr_strobe_n <= ASR_RST_STROBE_N;
            pins.word_address_pins <= '0;
            pins.data_pins_out <= '0;
            pins.data_pins_oe <= 1'b0;
        end else begin
            pins <= next_pins;
        end
    end

    // ==========================================================
    // Answer
    always_comb begin
        next_rsp_valid = 1'b0;
        next_rsp_write = rsp_write;
        next_rsp_rdata = rsp_rdata;
        case (state)
            ASR_RD_WAIT: begin
                if (cnt_done) begin
                    // Filter output has settled on the bus value by now
                    next_rsp_rdata = data_sync;
                    next_rsp_write = 1'b0;
                    next_rsp_valid = 1'b1;
                end
            end
            ASR_WR_HOLD: begin
                next_rsp_write = 1'b1;
                next_rsp_valid = 1'b1;
            end
            default: begin
                next_rsp_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_write <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= next_rsp_valid;
            rsp_write <= next_rsp_write;
            rsp_rdata <= next_rsp_rdata;
        end
    end
endmodule // asr_ctrl

// ===== inc/asr_pkg.sv
package asr_pkg;

    // ==========================================================
    // Memory geometry
    localparam int ASR_ADDR_W = 17;
    localparam int ASR_DATA_W = 8;
    localparam int ASR_DEPTH = 131072;

    // ==========================================================
    // Timing in ns, and the derived cycle counts
    localparam int ASR_CLK_NS = 8;
    localparam int ASR_T_AA_NS = 55;
    localparam int ASR_T_PWE_NS = 45;
    localparam int ASR_DATA_SETUP_NS = 25;
    localparam int ASR_STROBE_FLOAT_NS = 20;
    localparam int ASR_T_HZOE_NS = 20;
    // Three flops plus the register that waits for stages two and three to agree
    localparam int ASR_SYNC_LAT = 4;
    localparam int ASR_PWE_RAW = (ASR_T_PWE_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
    localparam int ASR_SUM_RAW = (ASR_STROBE_FLOAT_NS + ASR_DATA_SETUP_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
    localparam logic [3:0] ASR_RD_CYC = 4'((ASR_T_AA_NS + ASR_CLK_NS - 1) / ASR_CLK_NS + ASR_SYNC_LAT);
    localparam logic [3:0] ASR_WE_CYC = 4'((ASR_PWE_RAW > ASR_SUM_RAW) ? ASR_PWE_RAW : ASR_SUM_RAW);
    localparam logic [3:0] ASR_TURN_CYC = 4'((ASR_T_HZOE_NS + ASR_CLK_NS - 1) / ASR_CLK_NS);

    // ==========================================================
    // Reset values of the pins
    localparam logic ASR_RST_SEL_N = 1'b1;
    localparam logic ASR_RST_SEL = 1'b0;
    localparam logic ASR_RST_GATE_N = 1'b1;
    localparam logic ASR_RST_STROBE_N = 1'b1;

    // ==========================================================
    // Types
    typedef struct packed {
        logic write;
        logic [ASR_ADDR_W-1:0] addr;
        logic [ASR_DATA_W-1:0] wdata;
    } asr_req_t;

    typedef struct packed {
        logic select_active_low;
        logic select_active_high;
        logic out_gate_n;
        logic wr_strobe_n;
        logic [ASR_ADDR_W-1:0] word_address_pins;
        logic [ASR_DATA_W-1:0] data_pins_out;
        logic data_pins_oe;
    } asr_pins_t;

    typedef enum logic [5:0] {
        ASR_IDLE = 6'h01,
        ASR_RD_WAIT = 6'h02,
        ASR_RD_TURN = 6'h04,
        ASR_WR_SETUP = 6'h08,
        ASR_WR_STROBE = 6'h10,
        ASR_WR_HOLD = 6'h20
    } asr_state_t;

endpackage

// ===== hdl/asr_pin_sync.sv
`timescale 1ns/10ps
module asr_pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Pin side
    input wire logic [WIDTH-1:0] pin_in,
    // Synchronised value
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_pin_sync;

    // ==========================================================
    // Per-bit filter: a change counts once stages two and three agree
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            next_pin_sync[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_sync[i];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            pin_sync <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            pin_sync <= next_pin_sync;
        end
    end
endmodule // asr_pin_sync

// ===== testbench/asr_ctrl_props.sv
`timescale 1ns/10ps
module asr_ctrl_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Request and answer
    input wire logic req_valid,
    input wire asr_pkg::asr_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_write,
    input wire logic [asr_pkg::ASR_DATA_W-1:0] rsp_rdata,
    // Memory pins
    input wire asr_pkg::asr_pins_t pins,
    input wire logic [asr_pkg::ASR_DATA_W-1:0] data_pins_in
);
    import asr_pkg::*;
    // ====================
    // Pin protocol
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic sel;
    assign sel = !pins.select_active_low && pins.select_active_high;
    property p_no_fight; pins.data_pins_oe |-> pins.out_gate_n; endproperty
    a_no_fight: assert property (p_no_fight) else $error("data driven with gate low");
    property p_wr_gate; !pins.wr_strobe_n |-> pins.out_gate_n; endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("strobe low with gate low");
    property p_rd_gate; !pins.out_gate_n |-> sel && pins.wr_strobe_n && !pins.data_pins_oe; endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("gate low outside a read");
    property p_wr_start; $fell(pins.wr_strobe_n) |-> sel && pins.data_pins_oe; endproperty
    a_wr_start: assert property (p_wr_start) else $error("strobe fell unselected");
    property p_pulse; $fell(pins.wr_strobe_n) |-> (!pins.wr_strobe_n)[*6] ##1 pins.wr_strobe_n; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe pulse not 6 cycles");
    property p_end; $rose(pins.wr_strobe_n) |-> sel && pins.data_pins_oe && $stable(pins.data_pins_out)
        && $stable(pins.word_address_pins); endproperty
    a_end: assert property (p_end) else $error("data moved at write end");
    property p_addr; sel && $past(sel) |-> $stable(pins.word_address_pins); endproperty
    a_addr: assert property (p_addr) else $error("address moved while selected");
    property p_rd_lat; req_valid && req_ready && !req.write |-> ##12 rsp_valid && !rsp_write; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat; req_valid && req_ready && req.write |-> ##9 rsp_valid && rsp_write; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_idle; req_ready |-> !sel && pins.wr_strobe_n && !pins.data_pins_oe; endproperty
    a_idle: assert property (p_idle) else $error("memory selected while idle");
    c_rd: cover property (rsp_valid && !rsp_write);
    c_wr: cover property (rsp_valid && rsp_write);
    c_end: cover property ($rose(pins.wr_strobe_n));
endmodule // asr_ctrl_props
bind asr_ctrl asr_ctrl_props i_asr_ctrl_props (.core_clk, .resetn, .req_valid, .req, .req_ready,
    .rsp_valid, .rsp_write, .rsp_rdata, .pins, .data_pins_in);

// ===== testbench/asr_sram_model.sv
`timescale 1ns/10ps
module asr_sram_model #(
    parameter int ACC_NS = 40
) (
    // Pins from the controller
    input wire asr_pkg::asr_pins_t pins,
    input wire logic [asr_pkg::ASR_DATA_W-1:0] bus_level,
    // Read drive
    output logic [asr_pkg::ASR_DATA_W-1:0] rd_data,
    output logic rd_oe
);
    import asr_pkg::*;
    // ====================
    // Array and pin decode
    logic [ASR_DATA_W-1:0] mem [ASR_DEPTH];
    logic sel;
    logic wr_on;
    assign sel = !pins.select_active_low && pins.select_active_high;
    assign wr_on = sel && !pins.wr_strobe_n;
    // No drive on deselect, so a deselect with the strobe rise never glitches out
    assign rd_oe = sel && !pins.out_gate_n && pins.wr_strobe_n;
    assign #(ACC_NS) rd_data = mem[pins.word_address_pins];
    always begin
        @(posedge wr_on);
        @(negedge wr_on);
        mem[pins.word_address_pins] = bus_level;
    end
endmodule // asr_sram_model

// ===== testbench/async_sram_128k_x8_port_tb_top.sv
`timescale 1ns/10ps
module async_sram_128k_x8_port_tb_top;
    import asr_pkg::*;
    logic core_clk;
    logic resetn;
    logic req_valid;
    asr_req_t req;
    logic req_ready;
    logic rsp_valid;
    logic rsp_write;
    logic [ASR_DATA_W-1:0] rsp_rdata;
    asr_pins_t pins;
    logic [ASR_DATA_W-1:0] lvl;
    logic [ASR_DATA_W-1:0] last_lvl = 8'h00;
    logic [ASR_DATA_W-1:0] m_data;
    logic m_oe;
    logic [ASR_DATA_W-1:0] ref_mem [int];
    logic [ASR_ADDR_W-1:0] used [$];
    logic [ASR_ADDR_W-1:0] a;
    int failures;
    int n_checks;
    int seed;
    // ====================
    // Clock, bus and instances
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // A floating bus shows the inverse of its last level so stale data cannot pass
    assign lvl = pins.data_pins_oe ? pins.data_pins_out : (m_oe ? m_data : ~last_lvl);
    always @(posedge core_clk) last_lvl <= lvl;
    asr_ctrl i_asr_ctrl (.core_clk, .resetn, .req_valid, .req, .req_ready, .rsp_valid, .rsp_write,
        .rsp_rdata, .pins, .data_pins_in(lvl));
    // Model answers at the slowest access time the controller must cope with
    asr_sram_model #(.ACC_NS(ASR_T_AA_NS)) i_asr_sram_model (.pins, .bus_level(lvl), .rd_data(m_data),
        .rd_oe(m_oe));
    // ====================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    always @(posedge core_clk) if (pins.data_pins_oe === 1'b1 && m_oe === 1'b1) check("fight", 1, 0);
    task automatic op(input logic w, input logic [ASR_ADDR_W-1:0] ad, input logic [ASR_DATA_W-1:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        req_valid = 1'b1;
        req = '{w, ad, d};
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        req = asr_req_t'($random(seed));
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("lat", w ? n == ASR_WE_CYC + 2 : n == ASR_RD_CYC, 1);
        check("rsp_write", rsp_write, w);
        if (w) ref_mem[ad] = d;
        else check("rdata", rsp_rdata, ref_mem[ad]);
        if (!w) check("turn", req_ready, 1'b0);
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        final_report();
    end
    // ====================
    // Tests
    initial begin
        seed = 75;
        failures = 0;
        n_checks = 0;
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (3) @(posedge core_clk);
        #1;
        check("idle", {pins.select_active_low, pins.select_active_high, pins.data_pins_oe}, 3'b100);
        resetn = 1'b1;
        op(1, 17'h00000, 8'hA5);
        op(1, 17'h1FFFF, 8'h5A);
        op(0, 17'h00000, 8'h00);
        op(0, 17'h1FFFF, 8'h00);
        $display("test bounds done");
        for (int i = 0; i < 24; i++) begin
            a = ASR_ADDR_W'($random(seed));
            used.push_back(a);
            op(1, a, 8'($random(seed)));
            op(0, used[$unsigned($random(seed)) % used.size()], 8'h00);
        end
        $display("test random done");
        // Wait out the read turnaround so the cut write is really taken
        while (req_ready !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        req_valid = 1'b1;
        req = '{1'b1, 17'h0F0F0, 8'h3C};
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        resetn = 1'b0;
        #1;
        check("rst", {pins.select_active_low, pins.wr_strobe_n, pins.data_pins_oe}, 3'b110);
        @(posedge core_clk);
        #1;
        resetn = 1'b1;
        op(0, 17'h1FFFF, 8'h00);
        $display("test reset done");
        final_report();
    end
endmodule // async_sram_128k_x8_port_tb_top
